// ---- phy_status_led_driver.sv ----
// Status LED driver for the built-in PHY: duplex/collision, speed, link/activity
//
// Behaviour
// - Duplex LED low on full-duplex link, high on half-duplex without collision.
// - Half-duplex collision drives duplex LED low 80 ms, then high at least 80 ms.
// - Speed LED low at 100 Mbps, high at 10 Mbps.
// - Link LED low while link is up, high while link has failed.
// - With link up, activity pulses the link LED high for 80 ms.
// - After a pulse, link LED stays low 80 ms; repeats only if activity persists.
// - Held in reset while reset pin is low; configuration captured on its rise.
`timescale 1ns/1ps
`default_nettype none
module phy_status_led_driver
  import phy_led_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYCLES_DEFAULT
) (
  // Clock and core reset
  input wire logic clk,
  input wire logic rst,
  // Device reset pin and power-on setting
  input wire logic reset_in_low,
  input wire logic blink_strap,
  // PHY status indications
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic speed_100,
  input wire logic collision,
  input wire logic activity,
  // LED outputs, active low
  output var logic duplex_col_led_n,
  output var logic speed_led_n,
  output var logic link_activity_led_n
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic prev_reset_in_low;
  logic held;
  logic release_edge;
  logic blink_enable;
  link_mode_t link_mode;
  link_mode_t next_link_mode;
  logic speed_fast;
  logic collision_seen;
  logic activity_seen;
  logic col_clear;
  logic col_trigger;
  logic col_lit;
  logic act_clear;
  logic act_trigger;
  logic act_lit;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Speed and link/activity lamps both hinge on a live link
  function automatic logic link_live(input link_mode_t mode);
    link_live = (mode != LINK_DOWN);
  endfunction : link_live

  // ****************************************************************
  // Device reset pin
  // ****************************************************************
  assign held = !reset_in_low;
  assign release_edge = reset_in_low && !prev_reset_in_low;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reset_in_low <= 1'h0;
    end else begin
      prev_reset_in_low <= reset_in_low;
    end
  end

  // Strap is sampled on the release edge only, never under the async reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_enable <= BLINK_STRAP_DEFAULT;
    end else if (release_edge) begin
      blink_enable <= blink_strap;
    end
  end

  // ****************************************************************
  // PHY status capture
  // ****************************************************************
  always_comb begin
    if (!link_up) begin
      next_link_mode = LINK_DOWN;
    end else if (full_duplex) begin
      next_link_mode = LINK_FULL;
    end else begin
      next_link_mode = LINK_HALF;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_mode <= LINK_DOWN;
    end else if (held) begin
      link_mode <= LINK_DOWN;
    end else begin
      link_mode <= next_link_mode;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_fast <= 1'h0;
    end else if (held) begin
      speed_fast <= 1'h0;
    end else begin
      speed_fast <= speed_100;
    end
  end

  // Event indications are taken as levels; a level that lasts past the
  // gap restarts the blink, as the PHY keeps reporting it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      collision_seen <= 1'h0;
      activity_seen <= 1'h0;
    end else if (held) begin
      collision_seen <= 1'h0;
      activity_seen <= 1'h0;
    end else begin
      collision_seen <= collision;
      activity_seen <= activity;
    end
  end

  // ****************************************************************
  // Blink sequencers
  // ****************************************************************
  // Collision blinking only means something on a half-duplex link
  assign col_clear = held || (link_mode != LINK_HALF);
  assign col_trigger = collision_seen && blink_enable && (link_mode == LINK_HALF);

  blink_timer #(
    .CYCLES(BLINK_CYCLES)
  ) collision_blink (
    .clk(clk),
    .rst(rst),
    .clear(col_clear),
    .trigger(col_trigger),
    .lit(col_lit),
    .busy()
  );

  // A lost link aborts a pulse in progress so the LED shows the failure at once
  assign act_clear = held || !link_live(link_mode);
  assign act_trigger = activity_seen && blink_enable && link_live(link_mode);

  blink_timer #(
    .CYCLES(BLINK_CYCLES)
  ) activity_blink (
    .clk(clk),
    .rst(rst),
    .clear(act_clear),
    .trigger(act_trigger),
    .lit(act_lit),
    .busy()
  );

  // ****************************************************************
  // Duplex / collision LED
  // ****************************************************************
  // Leaving half duplex clears the collision sequencer, so no stale blink shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duplex_col_led_n <= LED_RESET;
    end else if (held) begin
      duplex_col_led_n <= LED_RESET;
    end else begin
      case (link_mode)
        LINK_FULL: begin
          duplex_col_led_n <= LED_ON;
        end
        LINK_HALF: begin
          duplex_col_led_n <= col_lit ? LED_ON : LED_OFF;
        end
        default: begin
          duplex_col_led_n <= LED_OFF;
        end
      endcase
    end
  end

  // ****************************************************************
  // Speed LED
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_led_n <= LED_RESET;
    // Without a link the speed is meaningless, so the lamp stays dark
    end else if (held || !link_live(link_mode)) begin
      speed_led_n <= LED_OFF;
    end else begin
      speed_led_n <= speed_fast ? LED_ON : LED_OFF;
    end
  end

  // ****************************************************************
  // Link / activity LED
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link_activity_led_n <= LED_RESET;
    // Pulse length comes from the sequencer; this flop only adds one cycle of lag
    end else if (held || !link_live(link_mode)) begin
      link_activity_led_n <= LED_OFF;
    end else if (act_lit) begin
      link_activity_led_n <= LED_OFF;
    end else begin
      link_activity_led_n <= LED_ON;
    end
  end

endmodule : phy_status_led_driver
`default_nettype wire

// ---- phy_led_pkg.sv ----
// Shared constants and types for the PHY status LED driver
package phy_led_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int BLINK_TIME_MS = 80;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  // 80 ms at the core clock rate: 8,000,000 cycles
  localparam int BLINK_CYCLES_DEFAULT = BLINK_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);

  // ****************************************************************
  // LED levels and reset values
  // ****************************************************************
  localparam logic LED_ON = 1'h0;
  localparam logic LED_OFF = 1'h1;
  localparam logic LED_RESET = LED_OFF;
  // Blinking is enabled unless the strap says otherwise at reset release
  localparam logic BLINK_STRAP_DEFAULT = 1'h1;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    BLINK_IDLE,
    BLINK_ON,
    BLINK_GAP
  } blink_state_t;

  typedef enum logic [1:0] {
    LINK_DOWN,
    LINK_HALF,
    LINK_FULL
  } link_mode_t;

endpackage : phy_led_pkg

// ---- blink_timer.sv ----
// One-shot blink sequencer: a lit phase of fixed length, then an equal dark gap
`timescale 1ns/1ps
`default_nettype none
module blink_timer
  import phy_led_pkg::*;
#(
  parameter int CYCLES = BLINK_CYCLES_DEFAULT,
  parameter int CNT_W = $clog2(CYCLES + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire logic trigger,
  // Status
  output logic lit,
  output logic busy
);

  blink_state_t state;
  logic [CNT_W-1:0] count;
  logic phase_done;

  function automatic logic last_cycle(input logic [CNT_W-1:0] value);
    last_cycle = (value == CNT_W'(CYCLES - 1));
  endfunction : last_cycle

  assign phase_done = last_cycle(count);
  assign lit = (state == BLINK_ON);
  assign busy = (state != BLINK_IDLE);

  // ****************************************************************
  // Phase sequencing
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= BLINK_IDLE;
    end else if (clear) begin
      state <= BLINK_IDLE;
    end else begin
      case (state)
        BLINK_IDLE: begin
          if (trigger) begin
            state <= BLINK_ON;
          end
        end
        BLINK_ON: begin
          if (phase_done) begin
            state <= BLINK_GAP;
          end
        end
        BLINK_GAP: begin
          // Back to idle; a trigger still present restarts next cycle
          if (phase_done) begin
            state <= BLINK_IDLE;
          end
        end
        default: begin
          state <= BLINK_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Interval counter
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear || state == BLINK_IDLE || phase_done) begin
      count <= '0;
    end else begin
      count <= count + CNT_W'(1);
    end
  end

endmodule : blink_timer
`default_nettype wire

// ---- phy_led_sva.sv ----
// Port checker for the PHY status LED driver
`timescale 1ns/1ps
`default_nettype none
module phy_led_sva #(
  parameter int BLINK_CYCLES = 8
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_in_low,
  // Status in, LEDs out
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic speed_100,
  input wire logic collision,
  input wire logic duplex_col_led_n,
  input wire logic speed_led_n,
  input wire logic link_activity_led_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ok;
  logic half;
  logic saw;
  int hi;
  int lo;
  int dlo;
  assign ok = reset_in_low && link_up;
  assign half = ok && !full_duplex;
  // ****************************************
  // Run lengths
  // ****************************************
  // Runs restart on link loss so a dropped link never looks like a pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi <= 0;
      lo <= 0;
      saw <= 1'h0;
    end else begin
      hi <= (ok && link_activity_led_n) ? hi + 1 : 0;
      lo <= (ok && !link_activity_led_n) ? lo + 1 : 0;
      saw <= ok && (saw || (!link_activity_led_n && hi == BLINK_CYCLES));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dlo <= 0;
    end else begin
      dlo <= (half && !duplex_col_led_n) ? dlo + 1 : 0;
    end
  end
  sequence s_quiet;
    (half && !collision)[*8];
  endsequence
  a_full_dup_led: assert property ((ok && full_duplex)[*3] |-> !duplex_col_led_n)
    else $error("duplex led dark in full duplex");
  a_half_dup_led: assert property (s_quiet ##1 s_quiet |-> duplex_col_led_n)
    else $error("duplex led lit in quiet half duplex");
  a_col_low_len: assert property (half |-> dlo <= BLINK_CYCLES)
    else $error("collision blink too long");
  a_speed_led: assert property (($stable(speed_100) && ok)[*3] |-> speed_led_n == !speed_100)
    else $error("speed led wrong");
  a_link_down: assert property ((reset_in_low && !link_up)[*3] |-> link_activity_led_n)
    else $error("link led lit with link down");
  a_act_high_len: assert property ($fell(link_activity_led_n) && ok && hi > 3 |-> hi == BLINK_CYCLES)
    else $error("activity pulse length wrong");
  a_act_gap_len: assert property ($rose(link_activity_led_n) && saw && ok && $past(ok, 2) |-> lo >= BLINK_CYCLES)
    else $error("activity gap too short");
  a_pin_reset: assert property ((!reset_in_low)[*2] |-> duplex_col_led_n && speed_led_n && link_activity_led_n)
    else $error("led lit in pin reset");
endmodule : phy_led_sva
bind phy_status_led_driver phy_led_sva #(.BLINK_CYCLES(BLINK_CYCLES)) sva_u (.clk, .rst, .reset_in_low, .link_up,
  .full_duplex, .speed_100, .collision, .duplex_col_led_n, .speed_led_n, .link_activity_led_n);
`default_nettype wire

// ---- led_panel.sv ----
// Model of the indicator lamp on the link/activity LED output
`timescale 1ns/1ps
`default_nettype none
module led_panel (
  // Clock and counter clear
  input wire logic clk,
  input wire logic clr,
  // Lamp drive, active low
  input wire logic link_activity_led_n,
  // Blinks seen
  output logic [7:0] act_offs
);
  logic prev;
  // Counts dark turns of the link lamp; the bench holds it clear until the activity cases begin
  always_ff @(posedge clk) begin
    prev <= link_activity_led_n;
    act_offs <= clr ? 8'h00 : act_offs + 8'(link_activity_led_n && !prev);
  end
endmodule : led_panel
`default_nettype wire

// ---- phy_status_led_driver_tb_top.sv ----
// Self-checking bench for the PHY status LED driver
`timescale 1ns/1ps
`default_nettype none
module phy_status_led_driver_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic reset_in_low = 1'h0;
  logic blink_strap = 1'h1;
  logic link_up = 1'h0;
  logic full_duplex = 1'h0;
  logic speed_100 = 1'h0;
  logic collision = 1'h0;
  logic activity = 1'h0;
  logic clr = 1'h1;
  logic dup_n;
  logic spd_n;
  logic lnk_n;
  logic [7:0] offs;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Link, full, fast in; duplex, speed, link LEDs out
  logic [5:0] rows [5] = '{6'h1f, 6'h38, 6'h2c, 6'h32, 6'h26};
  phy_status_led_driver #(.BLINK_CYCLES(8)) dut_u (.clk, .rst, .reset_in_low, .blink_strap, .link_up, .full_duplex,
    .speed_100, .collision, .activity, .duplex_col_led_n(dup_n), .speed_led_n(spd_n), .link_activity_led_n(lnk_n));
  led_panel panel_u (.clk, .clr, .link_activity_led_n(lnk_n), .act_offs(offs));
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic poke(input int n);
    activity = 1'h1;
    step(n);
    activity = 1'h0;
  endtask : poke
  task automatic end_sim;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // Generous ceiling: the whole run needs about two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    step(12);
    rst = 1'h0;
    step(1);
    reset_in_low = 1'h1;
    foreach (rows[i]) begin
      {link_up, full_duplex, speed_100} = rows[i][5:3];
      step(3);
      chk(8'({dup_n, spd_n, lnk_n}), 8'(rows[i][2:0]));
    end
    clr = 1'h0;
    poke(1);
    step(4);
    chk(8'(lnk_n), 8'h01);
    poke(1);
    step(30);
    chk(offs, 8'h01);
    poke(30);
    step(30);
    chk(offs, 8'h03);
    collision = 1'h1;
    step(1);
    collision = 1'h0;
    step(4);
    chk(8'(dup_n), 8'h00);
    step(9);
    // A collision in the dark gap must not start a blink; wait long enough to see one
    collision = 1'h1;
    step(1);
    collision = 1'h0;
    step(4);
    chk(8'(dup_n), 8'h01);
    reset_in_low = 1'h0;
    blink_strap = 1'h0;
    step(2);
    chk(8'({dup_n, spd_n, lnk_n}), 8'h07);
    reset_in_low = 1'h1;
    step(1);
    blink_strap = 1'h1;
    step(3);
    poke(1);
    step(4);
    chk(8'(lnk_n), 8'h00);
    reset_in_low = 1'h0;
    step(2);
    reset_in_low = 1'h1;
    step(3);
    poke(1);
    step(3);
    reset_in_low = 1'h0;
    step(2);
    reset_in_low = 1'h1;
    step(3);
    poke(1);
    step(4);
    chk(8'(lnk_n), 8'h01);
    step(30);
    end_sim();
  end
endmodule : phy_status_led_driver_tb_top
`default_nettype wire
